// ### acm_bit_timer.sv
// Shared constants for the serial port and the bit timer used by both directions.
`timescale 1ns/10ps

package acm_pkg;

	// ----------------------------------------------------------------
	// Register offsets on the plain register port.
	// ----------------------------------------------------------------
	localparam logic [2:0] OFS_RX_CTL = 3'h0;
	localparam logic [2:0] OFS_TX_CTL = 3'h1;
	localparam logic [2:0] OFS_DIVISOR = 3'h2;
	localparam logic [2:0] OFS_TX_BUF = 3'h3;
	localparam logic [2:0] OFS_RX_BUF = 3'h4;
	localparam logic [2:0] OFS_MODE = 3'h5;
	localparam logic [2:0] OFS_PORT_DIR = 3'h6;
	localparam logic [2:0] OFS_PORT_LATCH = 3'h7;

	// ----------------------------------------------------------------
	// Field positions of receive_control_reg.
	// ----------------------------------------------------------------
	localparam int RC_RANGE_SEL = 7;
	localparam int RC_START_DET = 6;
	localparam int RC_RUNNING = 5;
	localparam int RC_STOP_ERR = 4;
	localparam int RC_SPARE = 3;
	localparam int RC_BIT8 = 2;
	localparam int RC_END = 1;
	localparam int RC_IRQ_EN = 0;

	// ----------------------------------------------------------------
	// Field positions of transmit_control_reg.
	// ----------------------------------------------------------------
	localparam int TC_RUNNING = 7;
	localparam int TC_NINE_BIT = 6;
	localparam int TC_OUT_EN = 5;
	localparam int TC_OUT_TYPE = 4;
	localparam int TC_SEVEN_BIT = 3;
	localparam int TC_BIT8 = 2;
	localparam int TC_XFER_END = 1;
	localparam int TC_XFER_IRQ_EN = 0;

	// ----------------------------------------------------------------
	// Field positions of serial_mode_select_reg, port bits, reset value.
	// ----------------------------------------------------------------
	localparam int MD_GP_HI = 7;
	localparam int MD_GP_LO = 5;
	localparam int MD_OP_HI = 4;
	localparam int MD_OP_LO = 3;
	localparam int MD_MANCH = 2;
	localparam int MD_TX_END = 1;
	localparam int MD_TX_END_IRQ_EN = 0;
	localparam int PORT_TX_BIT = 0;
	localparam int PORT_RX_BIT = 1;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Operating modes and frame figures.
	// ----------------------------------------------------------------
	localparam logic [1:0] OP_PROG = 2'h0;
	localparam int DATA_BITS_STD = 8;
	localparam int DATA_BITS_LONG = 9;
	localparam int DATA_BITS_SHORT = 7;
	localparam int FIX_EVEN_DATA_BIT = 4;
	localparam int GAP_BITS_MAX = 3;
	localparam int TW = 24;

	// ----------------------------------------------------------------
	// Timing: clock, rates and fixed-rate bit stretch figures.
	// ----------------------------------------------------------------
	localparam int MCLK_NS = 4;
	localparam int MCLK_HZ = 250000000;
	localparam int RATE1_BPS = 9600;
	localparam int RATE2_BPS = 4800;
	localparam int RATE3_BPS = 2400;
	localparam int DIV_NARROW = 8;
	localparam int DIV_WIDE = 32;
	localparam int SHORT_PERMILLE = 879;
	localparam int LONG_PERMILLE = 1025;
	localparam int PERMILLE = 1000;
	localparam int MANCH_EARLY_PCT = 43;
	localparam int PCT = 100;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} acm_rx_e;
	typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_START, TX_DATA, TX_STOP, TX_GAP,
		TX_RELOAD} acm_tx_e;

endpackage

// ----------------------------------------------------------------
// Bit timer: counts clocks within one bit and flags its last clock.
// ----------------------------------------------------------------
module acm_bit_timer
	import acm_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Control.
	input wire logic restart,
	input wire logic [acm_pkg::TW-1:0] len,
	// Status.
	output logic [acm_pkg::TW-1:0] cnt,
	output logic last
);

	typedef struct packed {
		logic [TW-1:0] cnt;
	} acm_tmr_s;

	acm_tmr_s st_q;
	acm_tmr_s st_d;

	// Restart wins so a new bit always begins at count zero.
	always_comb begin
		st_d = st_q;
		if (restart) begin
			st_d.cnt = '0;
		end else begin
			st_d.cnt = st_q.cnt + TW'(1);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// The last clock of a bit; a zero length is never asked for.
	assign cnt = st_q.cnt;
	assign last = (st_q.cnt == len - TW'(1));

endmodule

// ### acm_checker.sv
// Port assertions for serial port one.
`timescale 1ns/10ps
module acm_checker
	import acm_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Register port.
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Pins and requests.
	input wire logic pause_mode,
	input wire logic rx_pullup_en,
	input wire logic tx_pin_oe,
	input wire logic tx_pullup_en,
	input wire logic rx_irq,
	input wire logic tx_irq,
	input wire logic pause_wake
);
	typedef struct packed {
		logic [7:0] dv, dr, lt, tc;
		logic re, me;
	} acm_shadow_s;
	acm_shadow_s sh_q, sh_d;
	logic ten;

	// Shadow of bits only software writes, so hardware flags cannot mislead it.
	always_comb begin
		sh_d = sh_q;
		if (reg_wr) begin
			case (reg_addr)
				OFS_DIVISOR: sh_d.dv = reg_wdata;
				OFS_PORT_DIR: sh_d.dr = reg_wdata;
				OFS_PORT_LATCH: sh_d.lt = reg_wdata;
				OFS_TX_CTL: sh_d.tc = reg_wdata;
				OFS_RX_CTL: sh_d.re = reg_wdata[RC_IRQ_EN];
				OFS_MODE: sh_d.me = reg_wdata[MD_TX_END_IRQ_EN];
				default: ;
			endcase
		end
	end

	// Shadow register.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sh_q <= '0;
		end else begin
			sh_q <= sh_d;
		end
	end

	assign ten = sh_q.tc[TC_XFER_IRQ_EN] | sh_q.me;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence s_div_read;
		reg_rd && reg_addr == OFS_DIVISOR;
	endsequence

	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside a read");
	a_divisor_readback: assert property (s_div_read |=> reg_rdata == $past(sh_q.dv))
		else $error("divisor read back wrong");
	a_rx_pullup: assert property (!$past(reg_wr) && !sh_q.dr[PORT_RX_BIT]
		|-> rx_pullup_en == sh_q.lt[PORT_RX_BIT]) else $error("rx pull-up wrong");
	a_tx_pullup: assert property (!$past(reg_wr) && !sh_q.dr[PORT_TX_BIT] && sh_q.tc[TC_OUT_EN]
		|-> tx_pullup_en == (!sh_q.tc[TC_OUT_TYPE] && sh_q.lt[PORT_TX_BIT]))
		else $error("tx pull-up wrong");
	a_tx_blocked: assert property (!$past(reg_wr) && sh_q.dr[PORT_TX_BIT] |-> !tx_pin_oe)
		else $error("tx driven while direction is output");
	a_rx_irq_gate: assert property (rx_irq |-> $past(sh_q.re))
		else $error("rx request without enable");
	a_tx_irq_gate: assert property (tx_irq |-> $past(ten))
		else $error("tx request without enable");
	a_wake_follows: assert property (pause_wake == ($past(pause_mode) && (rx_irq || tx_irq)))
		else $error("wake does not follow requests");
endmodule

bind acm_serial_port_one acm_checker acm_checker_i (.mclk, .reset_n, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .pause_mode, .rx_pullup_en, .tx_pin_oe, .tx_pullup_en,
	.rx_irq, .tx_irq, .pause_wake);

// ### acm_peer_model.sv
// Remote serial peer: drives the receive line and decodes the transmit line.
`timescale 1ns/10ps
module acm_peer_model #(
	parameter int BIT = 32
)
(
	// Clock, transmit line and mode.
	input wire logic mclk,
	input wire logic tx_line,
	input wire logic manch,
	// Line into the block and decoded result.
	output logic rx_line,
	output int got_n,
	output logic [7:0] got_byte,
	output logic got_bad
);
	logic s [0:18];
	int i;
	int n;

	// The line idles high so each start bit gives the block a falling edge.
	initial begin
		rx_line = 1'b1;
		got_n = 0;
		got_byte = 8'h00;
		got_bad = 1'b0;
	end

	// One frame LSB first; callers give one or two stop bits at a fixed rate.
	task automatic send(input logic [7:0] b, input int gap);
		int k;
		for (k = 0; k < 9 + gap; k++) begin
			@(posedge mclk);
			rx_line <= (k == 0) ? 1'b0 : (k < 9) ? b[k-1] : 1'b1;
			repeat (BIT - 1) @(posedge mclk);
		end
	endtask

	// Samples the late half of the start bit and both halves of later coded bits, else bit centres; a half pair must differ.
	always begin
		@(negedge tx_line);
		n = manch ? 19 : 10;
		repeat (manch ? BIT / 4 : BIT / 2) @(posedge mclk);
		for (i = 0; i < n; i++) begin
			s[i] = tx_line;
			if (i < n - 1)
				repeat (manch ? BIT / 2 : BIT) @(posedge mclk);
		end
		got_bad = (s[0] !== 1'b0) || (!manch && s[9] !== 1'b1);
		for (i = 0; i < 8; i++) begin
			got_byte[i] = manch ? s[2 * i + 2] : s[i + 1];
			if (manch && s[2 * i + 1] === s[2 * i + 2])
				got_bad = 1'b1;
		end
		if (manch && (s[17] !== 1'b0 || s[18] !== 1'b1))
			got_bad = 1'b1;
		got_n = got_n + 1;
	end
endmodule

// ### acm_serial_port_one.sv
// Serial port one: continuous receive and transmit, Manchester transmit option, fixed-rate timing.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps


module acm_serial_port_one
	import acm_pkg::*;
#(
	parameter int TCYC_NS = 12,
	parameter int FIX1_CLKS = acm_pkg::MCLK_HZ / acm_pkg::RATE1_BPS,
	parameter int FIX2_CLKS = acm_pkg::MCLK_HZ / acm_pkg::RATE2_BPS,
	parameter int FIX3_CLKS = acm_pkg::MCLK_HZ / acm_pkg::RATE3_BPS
)
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset_n,
	// Register port.
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Processor state.
	input wire logic pause_mode,
	// Receive pin.
	input wire logic rx_pin,
	output logic rx_pullup_en,
	// Transmit pin.
	output logic tx_pin_o,
	output logic tx_pin_oe,
	output logic tx_pullup_en,
	// Interrupt requests and wake.
	output logic rx_irq,
	output logic tx_irq,
	output logic pause_wake
);

	// One third of an instruction cycle in clocks, never below one.
	localparam int THIRD_CLKS = (TCYC_NS / (3 * MCLK_NS) < 1) ? 1 : TCYC_NS / (3 * MCLK_NS);

	typedef struct packed {
		logic rx_s1;
		logic rx_s2;
		logic rx_s3;
		logic [7:0] rctl;
		logic [7:0] tctl;
		logic [7:0] divisor;
		logic [7:0] transmit_buffer;
		logic [7:0] receive_buffer;
		logic [7:0] mode;
		logic [7:0] pdir;
		logic [7:0] plat;
		acm_rx_e rx_st;
		logic [8:0] rx_sh;
		logic [3:0] rx_idx;
		acm_tx_e tx_st;
		logic [8:0] tx_sh;
		logic [3:0] tx_idx;
		logic [1:0] gap_seq;
		logic [1:0] gap_left;
		logic tx_o;
		logic tx_oe;
		logic tx_pu;
		logic rx_pu;
		logic rx_irq;
		logic tx_irq;
		logic wake;
		logic [7:0] rdata;
	} acm_port_s;

	acm_port_s st_q;
	acm_port_s st_d;

	logic [TW-1:0] rx_len;
	logic [TW-1:0] tx_len;
	logic [TW-1:0] rx_cnt;
	logic [TW-1:0] tx_cnt;
	logic rx_last;
	logic tx_last;
	logic rx_restart;
	logic tx_restart;

	// ----------------------------------------------------------------
	// Bit length per mode; fixed-rate bits are stretched or shrunk.
	// ----------------------------------------------------------------
	function automatic logic [TW-1:0] bit_len(input logic [1:0] op, input logic wide,
		input logic [7:0] dv, input logic short_bit);
		int base;
		int full;
		base = FIX1_CLKS;
		full = 0;
		if (op == OP_PROG) begin
			full = (int'(dv) + 1) * (wide ? DIV_WIDE : DIV_NARROW) * THIRD_CLKS;
		end else begin
			if (op == 2'h2) begin
				base = FIX2_CLKS;
			end else if (op == 2'h3) begin
				base = FIX3_CLKS;
			end
			full = short_bit ? base * SHORT_PERMILLE / PERMILLE
				: base * LONG_PERMILLE / PERMILLE;
		end
		return TW'(full);
	endfunction

	// ----------------------------------------------------------------
	// Frame shape helpers.
	// ----------------------------------------------------------------
	logic fixed_mode;
	logic [3:0] nbits;
	logic rx_short;
	logic tx_short;
	logic [TW-1:0] tx_edge;
	logic tx_cur;
	logic tx_coded;
	logic tx_line;

	always_comb begin
		fixed_mode = (st_q.mode[MD_OP_HI:MD_OP_LO] != OP_PROG);
		if (fixed_mode || (!st_q.tctl[TC_NINE_BIT] && !st_q.tctl[TC_SEVEN_BIT])) begin
			nbits = 4'(DATA_BITS_STD);
		end else if (st_q.tctl[TC_NINE_BIT]) begin
			nbits = 4'(DATA_BITS_LONG);
		end else begin
			nbits = 4'(DATA_BITS_SHORT);
		end
		rx_short = (st_q.rx_st == RX_START)
			|| (st_q.rx_st == RX_DATA && st_q.rx_idx == 4'(FIX_EVEN_DATA_BIT));
		tx_short = (st_q.tx_st == TX_START)
			|| (st_q.tx_st == TX_DATA && st_q.tx_idx == 4'(FIX_EVEN_DATA_BIT));
		rx_len = bit_len(st_q.mode[MD_OP_HI:MD_OP_LO], st_q.rctl[RC_RANGE_SEL], st_q.divisor,
			rx_short);
		tx_len = bit_len(st_q.mode[MD_OP_HI:MD_OP_LO], st_q.rctl[RC_RANGE_SEL], st_q.divisor,
			tx_short);
		// Mid-bit edge: half way, or early in long fixed-rate bits.
		if (!fixed_mode || tx_short) begin
			tx_edge = tx_len >> 1;
		end else begin
			tx_edge = TW'(int'(tx_len) * MANCH_EARLY_PCT / PCT);
		end
		// Bit value on the line; lead and gap bits stay high and plain.
		tx_cur = 1'b1;
		tx_coded = 1'b0;
		case (st_q.tx_st)
			TX_START: begin
				tx_cur = 1'b0;
				tx_coded = 1'b1;
			end
			TX_DATA: begin
				tx_cur = st_q.tx_sh[0];
				tx_coded = 1'b1;
			end
			TX_STOP: begin
				tx_coded = 1'b1;
			end
			default: begin
				tx_cur = 1'b1;
			end
		endcase
		// Manchester sends the inverse first, the true value after the edge.
		if (st_q.mode[MD_MANCH] && tx_coded) begin
			tx_line = (tx_cnt < tx_edge) ? !tx_cur : tx_cur;
		end else begin
			tx_line = tx_cur;
		end
		rx_restart = (st_q.rx_st == RX_IDLE) || rx_last;
		tx_restart = (st_q.tx_st == TX_IDLE) || (st_q.tx_st == TX_RELOAD) || tx_last;
	end

	// ----------------------------------------------------------------
	// Bit timers for each direction.
	// ----------------------------------------------------------------
	acm_bit_timer u_rx_timer (
		.mclk(mclk),
		.reset_n(reset_n),
		.restart(rx_restart),
		.len(rx_len),
		.cnt(rx_cnt),
		.last(rx_last)
	);

	acm_bit_timer u_tx_timer (
		.mclk(mclk),
		.reset_n(reset_n),
		.restart(tx_restart),
		.len(tx_len),
		.cnt(tx_cnt),
		.last(tx_last)
	);

	// ----------------------------------------------------------------
	// Next state: registers, receiver, transmitter and pin outputs.
	// ----------------------------------------------------------------
	always_comb begin
		logic rx_fall;
		logic rx_mid;
		logic frame_done;
		logic tx_begin;
		logic [8:0] word;
		st_d = st_q;
		// The first stage feeds only the second; edges are seen on later stages.
		st_d.rx_s1 = rx_pin;
		st_d.rx_s2 = st_q.rx_s1;
		st_d.rx_s3 = st_q.rx_s2;
		rx_fall = st_q.rx_s3 && !st_q.rx_s2;
		rx_mid = (rx_cnt == (rx_len >> 1));
		frame_done = 1'b0;
		tx_begin = 1'b0;
		word = '0;
		st_d.rdata = REG_RESET;

		// Software writes; hardware flag sets below override these clears.
		if (reg_wr) begin
			if (reg_addr == OFS_RX_CTL) begin
				st_d.rctl = reg_wdata;
				st_d.rctl[RC_RUNNING] = st_q.rctl[RC_RUNNING] && reg_wdata[RC_RUNNING];
				if (!reg_wdata[RC_START_DET] && !reg_wdata[RC_RUNNING]) begin
					st_d.rx_st = RX_IDLE;
				end
			end else if (reg_addr == OFS_TX_CTL) begin
				st_d.tctl = reg_wdata;
				if (reg_wdata[TC_RUNNING] && st_q.tx_st == TX_IDLE) begin
					tx_begin = 1'b1;
				end else if (!reg_wdata[TC_RUNNING]) begin
					st_d.tx_st = TX_IDLE;
				end
			end else if (reg_addr == OFS_DIVISOR) begin
				st_d.divisor = reg_wdata;
			end else if (reg_addr == OFS_TX_BUF) begin
				st_d.transmit_buffer = reg_wdata;
			end else if (reg_addr == OFS_RX_BUF) begin
				st_d.receive_buffer = reg_wdata;
			end else if (reg_addr == OFS_MODE) begin
				st_d.mode = reg_wdata;
			end else if (reg_addr == OFS_PORT_DIR) begin
				st_d.pdir = reg_wdata;
			end else begin
				st_d.plat = reg_wdata;
			end
		end

		// Reads answer in the next cycle only.
		if (reg_rd) begin
			if (reg_addr == OFS_RX_CTL) begin
				st_d.rdata = st_q.rctl;
			end else if (reg_addr == OFS_TX_CTL) begin
				st_d.rdata = st_q.tctl;
			end else if (reg_addr == OFS_DIVISOR) begin
				st_d.rdata = st_q.divisor;
			end else if (reg_addr == OFS_TX_BUF) begin
				st_d.rdata = st_q.transmit_buffer;
			end else if (reg_addr == OFS_RX_BUF) begin
				st_d.rdata = st_q.receive_buffer;
			end else if (reg_addr == OFS_MODE) begin
				st_d.rdata = st_q.mode;
			end else if (reg_addr == OFS_PORT_DIR) begin
				st_d.rdata = st_q.pdir;
			end else begin
				st_d.rdata = st_q.plat;
			end
		end

		// Receiver; it runs regardless of the pause state.
		case (st_q.rx_st)
			RX_IDLE: begin
				if (st_q.rctl[RC_START_DET] && !st_q.pdir[PORT_RX_BIT] && rx_fall) begin
					st_d.rctl[RC_RUNNING] = 1'b1;
					st_d.rx_st = RX_START;
				end
			end
			RX_START: begin
				if (rx_mid && st_q.rx_s2) begin
					// A glitch, not a start bit: drop back and wait again.
					st_d.rctl[RC_RUNNING] = 1'b0;
					st_d.rx_st = RX_IDLE;
				end else if (rx_last) begin
					st_d.rx_idx = '0;
					st_d.rx_st = RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_mid) begin
					st_d.rx_sh = {st_q.rx_s2, st_q.rx_sh[8:1]};
				end
				if (rx_last) begin
					st_d.rx_idx = st_q.rx_idx + 4'h1;
					if (st_q.rx_idx == nbits - 4'h1) begin
						st_d.rx_st = RX_STOP;
					end
				end
			end
			default: begin
				// Finish at mid stop bit so a back-to-back start edge is caught.
				if (rx_mid) begin
					word = st_q.rx_sh >> (4'(DATA_BITS_LONG) - nbits);
					st_d.receive_buffer = word[7:0];
					st_d.rctl[RC_BIT8] = (nbits == 4'(DATA_BITS_LONG)) ? word[8] : 1'b0;
					st_d.rctl[RC_STOP_ERR] = st_d.rctl[RC_STOP_ERR] | !st_q.rx_s2;
					st_d.rctl[RC_END] = 1'b1;
					st_d.rctl[RC_RUNNING] = 1'b0;
					st_d.rx_st = RX_IDLE;
				end
			end
		endcase

		// An abort write beats any receiver state change in the same cycle; a stop-bit step still loads its flags and buffer.
		if (reg_wr && reg_addr == OFS_RX_CTL
			&& !reg_wdata[RC_START_DET] && !reg_wdata[RC_RUNNING]) begin
			st_d.rctl[RC_RUNNING] = 1'b0;
			st_d.rx_st = RX_IDLE;
		end

		// Transmitter.
		case (st_q.tx_st)
			TX_LEAD: begin
				if (tx_last) begin
					st_d.tx_st = TX_START;
				end
			end
			TX_START: begin
				if (tx_last) begin
					st_d.tx_idx = '0;
					st_d.tx_st = TX_DATA;
				end
			end
			TX_DATA: begin
				if (tx_last) begin
					st_d.tx_sh = {1'b1, st_q.tx_sh[8:1]};
					st_d.tx_idx = st_q.tx_idx + 4'h1;
					if (st_q.tx_idx == nbits - 4'h1) begin
						st_d.tx_st = TX_STOP;
					end
				end
			end
			TX_STOP: begin
				if (tx_last) begin
					if (fixed_mode) begin
						// One to three extra stop bits, rotating.
						st_d.gap_left = st_q.gap_seq;
						st_d.gap_seq = (st_q.gap_seq == 2'(GAP_BITS_MAX)) ? 2'h1
							: st_q.gap_seq + 2'h1;
						st_d.tx_st = TX_GAP;
					end else begin
						frame_done = 1'b1;
					end
				end
			end
			TX_GAP: begin
				if (tx_last) begin
					st_d.gap_left = st_q.gap_left - 2'h1;
					if (st_q.gap_left == 2'h1) begin
						frame_done = 1'b1;
					end
				end
			end
			TX_RELOAD: begin
				// Running rises again one cycle after it fell.
				st_d.tctl[TC_RUNNING] = 1'b1;
				st_d.tx_sh = {st_q.tctl[TC_BIT8], st_q.transmit_buffer};
				st_d.tctl[TC_XFER_END] = 1'b1;
				st_d.tx_st = TX_START;
			end
			default: begin
				if (tx_begin) begin
					st_d.tx_sh = {reg_wdata[TC_BIT8], st_q.transmit_buffer};
					st_d.tctl[TC_XFER_END] = 1'b1;
					st_d.tx_st = TX_LEAD;
				end
			end
		endcase

		// Frame end: stop if the transfer end flag was never cleared.
		if (frame_done) begin
			st_d.tctl[TC_RUNNING] = 1'b0;
			if (st_d.tctl[TC_XFER_END]) begin
				st_d.mode[MD_TX_END] = 1'b1;
				st_d.tx_st = TX_IDLE;
			end else begin
				st_d.tx_st = TX_RELOAD;
			end
		end

		// Pins: open drain only pulls low; direction 1 keeps the port off.
		st_d.tx_o = st_q.tctl[TC_OUT_TYPE] ? tx_line : 1'b0;
		st_d.tx_oe = !st_q.pdir[PORT_TX_BIT] && st_q.tctl[TC_OUT_EN]
			&& (st_q.tctl[TC_OUT_TYPE] || !tx_line);
		st_d.tx_pu = !st_q.pdir[PORT_TX_BIT] && st_q.tctl[TC_OUT_EN]
			&& !st_q.tctl[TC_OUT_TYPE] && st_q.plat[PORT_TX_BIT];
		st_d.rx_pu = !st_q.pdir[PORT_RX_BIT] && st_q.plat[PORT_RX_BIT];

		// Requests follow flags and enables; either one wakes a paused core.
		st_d.rx_irq = st_q.rctl[RC_END] && st_q.rctl[RC_IRQ_EN];
		st_d.tx_irq = (st_q.tctl[TC_XFER_END] && st_q.tctl[TC_XFER_IRQ_EN])
			|| (st_q.mode[MD_TX_END] && st_q.mode[MD_TX_END_IRQ_EN]);
		st_d.wake = pause_mode && (st_d.rx_irq || st_d.tx_irq);
	end

	// ----------------------------------------------------------------
	// State register.
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
			st_q.rx_s1 <= 1'b1;
			st_q.rx_s2 <= 1'b1;
			st_q.rx_s3 <= 1'b1;
			st_q.tx_o <= 1'b1;
			st_q.gap_seq <= 2'h1;
			st_q.rx_st <= RX_IDLE;
			st_q.tx_st <= TX_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Every output comes straight from the state register.
	assign reg_rdata = st_q.rdata;
	assign rx_pullup_en = st_q.rx_pu;
	assign tx_pin_o = st_q.tx_o;
	assign tx_pin_oe = st_q.tx_oe;
	assign tx_pullup_en = st_q.tx_pu;
	assign rx_irq = st_q.rx_irq;
	assign tx_irq = st_q.tx_irq;
	assign pause_wake = st_q.wake;

endmodule

// ### acm_serial_port_one_tb.sv
// Self-checking bench for serial port one.
`timescale 1ns/10ps
module async_serial_continuous_manchester_tb;
	import acm_pkg::*;
	localparam int BIT = 32;
	logic mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pause_mode = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, b, got_byte;
	logic rx_pin, rx_pullup_en, tx_pin_o, tx_pin_oe, tx_pullup_en, rx_irq, tx_irq, pause_wake;
	logic manch = 1'b0, got_bad;
	wire tx_line;
	int got_n, err_total = 0, tests_run = 0, cyc = 0, k, j, m;
	integer seed = 32'h84d4;
	logic [7:0] xb [0:2];
	logic [7:0] erx [$];
	logic [7:0] etx [$];

	// Bit time is (3 + 1) * 8 thirds of a cycle, one clock each; fixed rate one is
	// shortened to the same nominal bit so that one peer decodes every mode.
	acm_serial_port_one #(.FIX1_CLKS(BIT)) acm_serial_port_one_i (.mclk, .reset_n,
		.reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .pause_mode, .rx_pin, .rx_pullup_en, .tx_pin_o,
		.tx_pin_oe, .tx_pullup_en, .rx_irq, .tx_irq, .pause_wake);
	acm_peer_model #(.BIT(BIT)) acm_peer_model_i (.mclk, .tx_line, .manch, .rx_line(rx_pin),
		.got_n, .got_byte, .got_bad);
	assign tx_line = tx_pin_oe ? tx_pin_o : (tx_pullup_en ? 1'b1 : 1'bz);

	always #2 mclk = ~mclk;

	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		tests_run++;
		if (got !== want) begin
			err_total++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, want);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] want);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk(reg_rdata, want);
	endtask

	// Bounded wait on a request level; running out is reported as a mismatch.
	task automatic wait_for(input logic tx, input logic lvl);
		int n;
		n = 0;
		while ((tx ? tx_irq : rx_irq) !== lvl && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		chk({7'h0, (tx ? tx_irq : rx_irq)}, {7'h0, lvl});
	endtask

	task automatic final_report;
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Hang guard.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report;
		end
	end

	// Every frame the peer decodes is matched against the model queue.
	always @(got_n) begin
		chk(got_byte, etx.size() > 0 ? etx.pop_front() : 8'hxx);
		chk({7'h0, got_bad}, 8'h00);
	end

	initial begin
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		for (k = 0; k < 8; k++)
			rd(k[2:0], REG_RESET);
		chk({7'h0, tx_pin_oe}, 8'h00);
		b = 8'($random(seed));
		wr(OFS_DIVISOR, b);
		rd(OFS_DIVISOR, b);
		wr(OFS_DIVISOR, 8'h03);
		wr(OFS_RX_CTL, 8'h41);
		// Three frames while paused, each serviced before the next start bit.
		for (k = 0; k < 3; k++) begin
			xb[k] = 8'($random(seed));
			erx.push_back(xb[k]);
		end
		pause_mode <= 1'b1;
		fork
			for (j = 0; j < 3; j++)
				acm_peer_model_i.send(xb[j], 2);
			for (k = 0; k < 3; k++) begin
				wait_for(1'b0, 1'b1);
				chk({7'h0, pause_wake}, 8'h01);
				rd(OFS_RX_BUF, erx.pop_front());
				rd(OFS_RX_CTL, 8'h43);
				wr(OFS_RX_CTL, 8'h41);
				wait_for(1'b0, 1'b0);
			end
		join
		pause_mode <= 1'b0;
		// Abort in mid-frame; the rest of the frame must leave no trace.
		fork
			acm_peer_model_i.send(8'h55, 1);
			begin
				repeat (3 * BIT) @(posedge mclk);
				rd(OFS_RX_CTL, 8'h61);
				wr(OFS_RX_CTL, 8'h01);
				rd(OFS_RX_CTL, 8'h01);
			end
		join
		repeat (BIT) @(posedge mclk);
		rd(OFS_RX_CTL, 8'h01);
		// Continuous transmit of three bytes in each of three modes: plain, Manchester, then plain at fixed rate one.
		for (m = 0; m < 3; m++) begin
			manch <= m[0];
			wr(OFS_MODE, {4'h0, m[1], m[0], 2'h1});
			for (k = 0; k < 3; k++) begin
				xb[k] = 8'($random(seed));
				etx.push_back(xb[k]);
			end
			wr(OFS_TX_BUF, xb[0]);
			wr(OFS_TX_CTL, 8'h31);
			repeat (2) @(negedge mclk);
			chk({7'h0, tx_line}, 8'h01);
			wr(OFS_TX_CTL, 8'hb1);
			for (k = 1; k < 4; k++) begin
				wait_for(1'b1, 1'b1);
				if (k < 3) begin
					wr(OFS_TX_BUF, xb[k]);
					wr(OFS_TX_CTL, 8'hb1);
				end else begin
					wr(OFS_TX_CTL, 8'hb2);
				end
				wait_for(1'b1, 1'b0);
			end
			wait_for(1'b1, 1'b1);
			rd(OFS_MODE, {4'h0, m[1], m[0], 2'h3});
			rd(OFS_TX_CTL, 8'h32);
			chk(8'(etx.size()), 8'h00);
			wr(OFS_MODE, 8'h00);
			chk({7'h0, tx_pin_o}, 8'h01);
		end
		// Pin set-up: pull-ups from the latch, output blocked by direction.
		wr(OFS_PORT_LATCH, 8'h03);
		wr(OFS_TX_CTL, 8'h20);
		repeat (2) @(posedge mclk);
		chk({7'h0, rx_pullup_en}, 8'h01);
		chk({7'h0, tx_pullup_en}, 8'h01);
		wr(OFS_PORT_DIR, 8'h03);
		repeat (2) @(posedge mclk);
		chk({7'h0, tx_pin_oe}, 8'h00);
		final_report;
	end
endmodule
